//--- refsel_pkg.sv
package refsel_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [11:0] ref_cfg_addr    = 12'h000;
    localparam logic [11:0] pll_cfg_addr    = 12'h004;
    localparam logic [11:0] crystal_load_trim_cfg_addr   = 12'h008;
    localparam logic [11:0] status_addr     = 12'h00c;
    localparam logic [11:0] pll_mult_addr   = 12'h010;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int primary_source_select_bit = 0;
    localparam int switch_mode_lo             = 1;
    localparam int switch_mode_hi             = 2;
    localparam int pll_sel_lo                 = 8;
    localparam int pll_sel_hi                 = 9;
    localparam int pre_div_lo                 = 0;
    localparam int pre_div_hi                 = 6;
    localparam int fb_lo                      = 16;
    localparam int fb_hi                      = 27;
    localparam int trim_lo                    = 0;
    localparam int trim_hi                    = 4;
    localparam int drive_lo                   = 8;
    localparam int drive_hi                   = 12;

    localparam logic [4:0] crystal_load_trim_rst      = 5'h00;
    localparam logic [4:0] crystal_drive_strength_rst = 5'h11;
    localparam logic [6:0] pre_div_rst                = 7'h01;
    localparam logic [11:0] fb_rst                    = 12'h001;

    // loss of primary after this many secondary edges without a primary edge
    localparam logic [1:0] loss_count          = 2'h2;
    localparam int         num_plls            = 4;
    localparam int         last_pll            = 3;
    // load trim in units of 0.125 pF: base 3.5 pF = 28 steps
    localparam logic [5:0] trim_base_steps     = 6'h1c;

    typedef enum logic [1:0] {sel_primary, sel_secondary} ref_state_t;

    typedef struct packed {
        logic [6:0]  pre_div;
        logic [11:0] fb_count;
    } pll_cfg_t;

endpackage : refsel_pkg

//--- edge_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser followed by a transition detector
module edge_sync
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      level_out,
    output logic      toggle_out
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_out  = sync_reg;
    assign toggle_out = sync_reg ^ last_reg;

endmodule : edge_sync

//--- ref_clock_select_switchover.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module ref_clock_select_switchover
#(
    parameter int pll_count = refsel_pkg::num_plls
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_ref_input,
    input  wire logic        aux_clock_input,
    input  wire logic        input_select_pin,
    output logic             use_aux_reg,
    output logic             secondary_active_reg,
    output logic [3:0]       pll_powerdown_reg,
    output logic [5:0]       load_cap_steps_reg
);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic                 primary_source_select_reg;
    logic [1:0]           switch_mode_reg;
    logic [1:0]           pll_sel_reg;
    logic [4:0]           crystal_load_trim_reg;
    logic [4:0]           crystal_drive_strength_reg;
    refsel_pkg::pll_cfg_t pll_cfg_reg [pll_count];
    logic [1:0]           miss_count_reg;
    refsel_pkg::ref_state_t state_reg;
    refsel_pkg::ref_state_t state_next;

    logic crystal_load_trim_level;
    logic crystal_load_trim_toggle;
    logic aux_level;
    logic aux_toggle;
    logic prim_toggle;
    logic sec_toggle;
    logic sec_rise;
    logic auto_mode;
    logic primary_lost;
    logic apb_wr;
    logic apb_rd;

    function automatic logic [11:0] eff_mult(input refsel_pkg::pll_cfg_t c);
        eff_mult = c.fb_count;
    endfunction : eff_mult

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;

    // ------------------------------------------------------------
    // input edge detection
    // ------------------------------------------------------------
    edge_sync u_sync_crystal_load_trim
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   (crystal_ref_input),
        .level_out  (crystal_load_trim_level),
        .toggle_out (crystal_load_trim_toggle)
    );

    edge_sync u_sync_aux
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   (aux_clock_input),
        .level_out  (aux_level),
        .toggle_out (aux_toggle)
    );

    // ------------------------------------------------------------
    // apb register writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            primary_source_select_reg  <= 1'b0;
            switch_mode_reg            <= 2'h0;
            pll_sel_reg                <= 2'h0;
            crystal_load_trim_reg      <= refsel_pkg::crystal_load_trim_rst;
            crystal_drive_strength_reg <= refsel_pkg::crystal_drive_strength_rst;
            for (int i = 0; i < pll_count; i++)
            begin
                pll_cfg_reg[i].pre_div  <= refsel_pkg::pre_div_rst;
                pll_cfg_reg[i].fb_count <= refsel_pkg::fb_rst;
            end
        end
        else if (apb_wr)
        begin
            case (paddr)
                refsel_pkg::ref_cfg_addr:
                begin
                    primary_source_select_reg <=
                        pwdata[refsel_pkg::primary_source_select_bit];
                    switch_mode_reg <=
                        pwdata[refsel_pkg::switch_mode_hi:refsel_pkg::switch_mode_lo];
                end
                refsel_pkg::pll_cfg_addr:
                begin
                    pll_sel_reg <= pwdata[refsel_pkg::pll_sel_hi:refsel_pkg::pll_sel_lo];
                end
                refsel_pkg::pll_mult_addr:
                begin
                    pll_cfg_reg[pll_sel_reg].pre_div <=
                        pwdata[refsel_pkg::pre_div_hi:refsel_pkg::pre_div_lo];
                    pll_cfg_reg[pll_sel_reg].fb_count <=
                        pwdata[refsel_pkg::fb_hi:refsel_pkg::fb_lo];
                end
                refsel_pkg::crystal_load_trim_cfg_addr:
                begin
                    crystal_load_trim_reg <=
                        pwdata[refsel_pkg::trim_hi:refsel_pkg::trim_lo];
                    crystal_drive_strength_reg <=
                        pwdata[refsel_pkg::drive_hi:refsel_pkg::drive_lo];
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb read and response
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    refsel_pkg::ref_cfg_addr:
                        prdata <= {29'h0, switch_mode_reg, primary_source_select_reg};
                    refsel_pkg::pll_cfg_addr:
                        prdata <= {22'h0, pll_sel_reg, 8'h00};
                    refsel_pkg::pll_mult_addr:
                        prdata <= {4'h0, eff_mult(pll_cfg_reg[pll_sel_reg]), 9'h000,
                                   pll_cfg_reg[pll_sel_reg].pre_div};
                    refsel_pkg::crystal_load_trim_cfg_addr:
                        prdata <= {19'h0, crystal_drive_strength_reg, 3'h0,
                                   crystal_load_trim_reg};
                    refsel_pkg::status_addr:
                        prdata <= {28'h0, aux_level, crystal_load_trim_level, use_aux_reg,
                                   secondary_active_reg};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // loss-of-primary detection
    // ------------------------------------------------------------
    assign prim_toggle = primary_source_select_reg ? aux_toggle : crystal_load_trim_toggle;
    assign sec_toggle  = primary_source_select_reg ? crystal_load_trim_toggle : aux_toggle;
    // rising edges only, so the count spans whole secondary periods
    assign sec_rise    = sec_toggle &&
                         (primary_source_select_reg ? crystal_load_trim_level : aux_level);
    assign auto_mode   = switch_mode_reg[1];
    assign primary_lost = (miss_count_reg == refsel_pkg::loss_count);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            miss_count_reg <= 2'h0;
        end
        else if (prim_toggle)
        begin
            miss_count_reg <= 2'h0;
        end
        else if (sec_rise && !primary_lost)
        begin
            miss_count_reg <= miss_count_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // selection state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            refsel_pkg::sel_primary:
            begin
                if (!auto_mode && input_select_pin)
                    state_next = refsel_pkg::sel_secondary;
                else if (auto_mode && primary_lost)
                    state_next = refsel_pkg::sel_secondary;
            end
            refsel_pkg::sel_secondary:
            begin
                if (!auto_mode && !input_select_pin)
                    state_next = refsel_pkg::sel_primary;
                else if (auto_mode && prim_toggle)
                    state_next = refsel_pkg::sel_primary;
            end
            default:
                state_next = refsel_pkg::sel_primary;
        endcase
    end

    // selection is a registered level; the clock mux downstream switches
    // glitch free on it, while direct routes may still see short pulses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg            <= refsel_pkg::sel_primary;
            secondary_active_reg <= 1'b0;
            use_aux_reg          <= 1'b0;
        end
        else
        begin
            state_reg            <= state_next;
            secondary_active_reg <= (state_next == refsel_pkg::sel_secondary);
            use_aux_reg          <= primary_source_select_reg ^
                                    (state_next == refsel_pkg::sel_secondary);
        end
    end

    // ------------------------------------------------------------
    // pll power-down and load trim
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_powerdown_reg  <= 4'h0;
            load_cap_steps_reg <= refsel_pkg::trim_base_steps;
        end
        else
        begin
            for (int i = 0; i < refsel_pkg::num_plls; i++)
            begin
                if (i < pll_count && i != refsel_pkg::last_pll)
                    pll_powerdown_reg[i] <= (pll_cfg_reg[i].pre_div == 7'h00);
                else
                    pll_powerdown_reg[i] <= 1'b0;
            end
            load_cap_steps_reg <= refsel_pkg::trim_base_steps +
                                  {1'b0, crystal_load_trim_reg};
        end
    end

endmodule : ref_clock_select_switchover

//--- refsel_sva.sv
`timescale 1ns/1ps
module refsel_sva
#(
    parameter int pll_count = refsel_pkg::num_plls
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        crystal_ref_input,
    input wire logic        input_select_pin,
    input wire logic        use_aux_reg,
    input wire logic        secondary_active_reg,
    input wire logic [3:0]  pll_powerdown_reg,
    input wire logic [5:0]  load_cap_steps_reg
);
    logic       wr;
    logic       prim_t;
    logic       auto_t;
    logic       pre0_t;
    logic [1:0] idx_t;
    logic [4:0] trim_t;
    logic [3:0] quiet;

    assign wr = psel && penable && pwrite && pready;

    // ------------------------------------------------------------
    // shadow of the configuration seen on the bus
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prim_t <= 1'b0;
            auto_t <= 1'b0;
            idx_t  <= 2'h0;
            trim_t <= 5'h00;
            pre0_t <= 1'b0;
        end
        else if (wr && paddr == refsel_pkg::ref_cfg_addr)
        begin
            prim_t <= pwdata[0];
            auto_t <= pwdata[2];
        end
        else if (wr && paddr == refsel_pkg::pll_cfg_addr)
            idx_t <= pwdata[9:8];
        else if (wr && paddr == refsel_pkg::crystal_load_trim_cfg_addr)
            trim_t <= pwdata[4:0];
        else if (wr && paddr == refsel_pkg::pll_mult_addr)
            pre0_t <= (pwdata[6:0] == 7'h00);
    end

    // cycles since the crystal reference input last moved, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            quiet <= 4'h0;
        else if ($changed(crystal_ref_input))
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_ZERO_WAIT: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_ERR_UNMAPPED: assert property (pslverr |-> pready && (paddr[1:0] != 2'h0
        || paddr > refsel_pkg::pll_mult_addr)) else $error("error on mapped address");
    AST_TRIM: assert property (wr && paddr == refsel_pkg::crystal_load_trim_cfg_addr
        |=> ##[0:1] load_cap_steps_reg == refsel_pkg::trim_base_steps + 6'(trim_t))
        else $error("load cap steps wrong");
    AST_PD: assert property (wr && paddr == refsel_pkg::pll_mult_addr && idx_t != 2'h3
        |=> ##[0:1] pll_powerdown_reg[idx_t] == pre0_t) else $error("powerdown wrong");
    AST_PD_LAST: assert property (pll_powerdown_reg[3] == 1'b0)
        else $error("last pll powered down");
    AST_MANUAL: assert property (!auto_t && $changed(input_select_pin)
        |-> ##[1:3] secondary_active_reg == input_select_pin) else $error("manual select");
    AST_AUX_MAP: assert property ($stable(prim_t) && $stable(secondary_active_reg)
        |-> use_aux_reg == (prim_t ^ secondary_active_reg)) else $error("aux map wrong");
    AST_NO_EARLY: assert property (auto_t && $rose(secondary_active_reg)
        |-> quiet > 4'h4) else $error("switch while primary alive");
    AST_REVERT: assert property (auto_t && secondary_active_reg && quiet == 4'h0
        |-> ##[1:6] !secondary_active_reg) else $error("no revert");
endmodule : refsel_sva

//--- refsel_clk_src.sv
`timescale 1ns/1ps
module refsel_clk_src
(
    input  wire logic crystal_load_trim_run,
    input  wire logic aux_run,
    output logic      crystal_load_trim_clk,
    output logic      aux_clk
);
    // external oscillator on the crystal pin, never a crystal
    initial
    begin
        crystal_load_trim_clk = 1'b0;
        forever #26 crystal_load_trim_clk = crystal_load_trim_run ? !crystal_load_trim_clk : crystal_load_trim_clk;
    end
    // secondary slower than primary
    initial
    begin
        aux_clk = 1'b0;
        forever #62 aux_clk = aux_run ? !aux_clk : aux_clk;
    end
endmodule : refsel_clk_src

//--- ref_clock_select_switchover_bench.sv
`timescale 1ns/1ps
module ref_clock_select_switchover_bench;
    logic        pclk, presetn, psel, penable, pwrite, pin, xr, ar, err;
    logic        xclk, aclk, pready, pslverr, use_aux, sec;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pd;
    logic [5:0]  cap;
    int          bad_count, n_tests, seed, i, t, fb;

    refsel_clk_src src (.crystal_load_trim_run(xr), .aux_run(ar), .crystal_load_trim_clk(xclk), .aux_clk(aclk));
    ref_clock_select_switchover #(.pll_count(4)) DUT
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_ref_input(xclk), .aux_clock_input(aclk), .input_select_pin(pin),
        .use_aux_reg(use_aux), .secondary_active_reg(sec), .pll_powerdown_reg(pd),
        .load_cap_steps_reg(cap)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] cap_exp(input int tr);
        return refsel_pkg::trim_base_steps + 6'(tr);
    endfunction : cap_exp

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge pclk);
        if (k == 20)
        begin
            bad_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_sec(input logic v);
        int k;
        for (k = 0; k < 3000 && sec !== v; k++)
            @(posedge pclk);
        chk(32'(sec), 32'(v));
        if (k == 3000)
            wrap_up();
    endtask : wait_sec

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 31;
        bad_count = 0;
        n_tests = 0;
        {presetn, psel, penable, pwrite, pin} = 5'h00;
        {xr, ar, paddr, pwdata} = {2'h3, 44'h0};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({use_aux, sec, pd, cap}), 32'h01c);
        apb(0, refsel_pkg::crystal_load_trim_cfg_addr, 0);
        chk(rd, 32'h1100);
        apb(0, refsel_pkg::status_addr, 0);
        chk(rd & 32'h3, 0);
        apb(1, 12'h014, 32'h1f);
        chk(32'({err, cap}), 32'h05c);
        apb(0, 12'h020, 0);
        chk({rd[30:0], err}, 1);
        for (i = 0; i < 6; i++)
        begin
            t = (i == 0) ? 31 : ($random(seed) & 31);
            apb(1, refsel_pkg::crystal_load_trim_cfg_addr, 32'h1100 | t);
            repeat (2) @(posedge pclk);
            chk(32'(cap), 32'(cap_exp(t)));
        end
        apb(1, refsel_pkg::crystal_load_trim_cfg_addr, 32'h1100);
        $display("test registers and trim done");
        for (i = 0; i < 4; i++)
        begin
            fb = 12 + ($random(seed) & 32'h7ff);
            t = (i == 3) ? 3 : 0;
            apb(1, refsel_pkg::pll_cfg_addr, i << 8);
            apb(1, refsel_pkg::pll_mult_addr, (fb << 16) | t);
            apb(0, refsel_pkg::pll_mult_addr, 0);
            chk(rd, (fb << 16) | t);
            chk(32'(pd[i]), 32'(i < 3));
            apb(1, refsel_pkg::pll_mult_addr, (fb << 16) | 127);
            repeat (2) @(posedge pclk);
            chk(32'(pd[i]), 0);
        end
        $display("test pll done");
        for (i = 0; i < 4; i++)
        begin
            apb(1, refsel_pkg::ref_cfg_addr, (i >> 1) | (($random(seed) & 1) << 1));
            pin <= i[0];
            repeat (6) @(posedge pclk);
            chk(32'({use_aux, sec}), 32'({i[1] ^ i[0], i[0]}));
        end
        pin <= 1'b0;
        apb(1, refsel_pkg::ref_cfg_addr, 32'h4);
        repeat (100) @(posedge pclk);
        chk(32'(sec), 0);
        xr <= 1'b0;
        wait_sec(1'b1);
        chk(32'(use_aux), 1);
        xr <= 1'b1;
        wait_sec(1'b0);
        {xr, ar} <= 2'h0;
        repeat (200) @(posedge pclk);
        chk(32'(sec), 0);
        ar <= 1'b1;
        wait_sec(1'b1);
        xr <= 1'b1;
        wait_sec(1'b0);
        $display("test switchover done");
        wrap_up();
    end
endmodule : ref_clock_select_switchover_bench

bind ref_clock_select_switchover refsel_sva #(.pll_count(pll_count)) sva_i
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .crystal_ref_input, .input_select_pin, .use_aux_reg, .secondary_active_reg,
    .pll_powerdown_reg, .load_cap_steps_reg
);
